// ==== hdl/lsal_lat_cnt.sv ====
`include "lsal_map.svh"

// Counts link clocks from link-ready rise to link-valid rise
module lsal_lat_cnt #(
  parameter int LAT_W = `LSAL_LAT_W
) (
  // Clock, reset, enable
  input logic core_clk,
  input logic sys_rst,
  input logic clk_en,
  // Link reset of this instance, already synchronised
  input logic link_rst_n,
  // Link layer status of this instance
  input logic tx_ready,
  input logic rx_valid,
  // Result
  output logic done,
  output logic [LAT_W-1:0] count
);

  typedef struct packed {
    lsal_pkg::lsal_lat_state_t st;
    logic tx_q;
    logic rx_q;
    logic [LAT_W-1:0] cnt;
  } lsal_lat_st_t;

  lsal_lat_st_t s_q;
  lsal_lat_st_t s_d;
  logic tx_rise;
  logic rx_rise;

  // Edge detection on same-clock status
  assign tx_rise = tx_ready & ~s_q.tx_q;
  assign rx_rise = rx_valid & ~s_q.rx_q;

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.tx_q = tx_ready;
    s_d.rx_q = rx_valid;
    case (s_q.st)
      lsal_pkg::LSAL_IDLE: begin
        if (tx_rise) begin
          s_d.cnt = '0;
          s_d.st = rx_rise ? lsal_pkg::LSAL_HOLD : lsal_pkg::LSAL_RUN;
        end
      end
      lsal_pkg::LSAL_RUN: begin
        if (rx_rise) begin
          s_d.st = lsal_pkg::LSAL_HOLD;
        end else if (s_q.cnt != '1) begin
          s_d.cnt = LAT_W'(s_q.cnt + 1'b1);
        end
      end
      lsal_pkg::LSAL_HOLD: s_d.st = lsal_pkg::LSAL_HOLD;
      default: s_d.st = lsal_pkg::LSAL_IDLE;
    endcase
    if (!link_rst_n) begin
      s_d.st = lsal_pkg::LSAL_IDLE;
      s_d.cnt = '0;
    end
    if (!clk_en) begin
      s_d = s_q;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_q <= '{st: lsal_pkg::LSAL_IDLE, tx_q: 1'b0, rx_q: 1'b0,
               cnt: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign done = (s_q.st == lsal_pkg::LSAL_HOLD);
  assign count = s_q.cnt;

endmodule

// ==== hdl/lsal_map.svh ====
`ifndef LSAL_MAP_SVH
`define LSAL_MAP_SVH

// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define LSAL_INST 2
`define LSAL_LANES 8
`define LSAL_DATA_W 256
`define LSAL_LAT_W 15
`define LSAL_STAT_W 32

// ---------------------------------------------------------------
// Pattern source encodings
// ---------------------------------------------------------------
`define LSAL_SRC_PRBS 2'h0
`define LSAL_SRC_RAMP 2'h1
`define LSAL_SRC_ALT 2'h2

// ---------------------------------------------------------------
// Expected status register 0 after a good bring-up
// ---------------------------------------------------------------
`define LSAL_TX_STAT0_OK 32'h0000_0005
`define LSAL_RX_STAT0_OK 32'h0000_0039

// ---------------------------------------------------------------
// Synchroniser reset values
// ---------------------------------------------------------------
`define LSAL_FRM_SYNC_W 7
`define LSAL_FRM_SYNC_RST 7'h7e
`define LSAL_LNK_SYNC_RST 2'h0

`endif

// ==== hdl/lsal_pkg.sv ====
`include "lsal_map.svh"

package lsal_pkg;

  // ---------------------------------------------------------------
  // Latency measurement states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LSAL_IDLE = 3'b001,
    LSAL_RUN = 3'b010,
    LSAL_HOLD = 3'b100
  } lsal_lat_state_t;

  // ---------------------------------------------------------------
  // Board indicators, bit 0 is the frame reset lamp
  // ---------------------------------------------------------------
  typedef struct packed {
    logic data_err;
    logic tx_irq;
    logic rx_irq;
    logic tx_sync;
    logic lanes_aligned;
    logic rx_sync;
    logic link_up;
    logic frame_up;
  } lsal_ind_t;

  // Pattern checker error status, active low, one bit per instance
  typedef struct packed {
    logic [`LSAL_INST-1:0] prbs_err_n;
    logic [`LSAL_INST-1:0] ramp_err_n;
    logic [`LSAL_INST-1:0] alt_err_n;
  } lsal_chk_t;

  // Latency result of one instance
  typedef struct packed {
    logic done;
    logic [`LSAL_LAT_W-1:0] count;
  } lsal_lat_t;

endpackage

// ==== hdl/lsal_sync2.sv ====
// Two-stage synchroniser for levels from another clock domain
module lsal_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock, reset, enable
  input logic core_clk,
  input logic sys_rst,
  input logic clk_en,
  // Levels
  input logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage is read only by the second stage
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else if (clk_en) begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// ==== hdl/lsal_top.sv ====
`include "lsal_map.svh"

// Overview of operation
// - The frame lamp lights once the synchronised frame reset is released.
// - The link lamp lights once the link resets of both cores are released.
// - The receive sync lamp lights once every receiver raises its sync.
// - Lanes-aligned is high only when all lanes of both instances align.
// - The receiver sync lines of both instances are ANDed for the sender.
// - The receive interrupt lamp lights while either core has one pending.
// - The transmit interrupt lamp lights while either core has one pending.
// - All active-low checker error bits are ANDed; a low result is an error.
// - Latency counts link clocks from link-ready rise to link-valid rise.
// - Receive output data carries the pattern picked by the source setting.
// - Status 0 must read 0x5 for transmit and 0x39 for receive on each core.
// - Good bring-up means five lamps lit and both irq and error lamps off.
// - Link and frame clocks are related outputs of one PLL.
module lsal_top #(
  parameter int LANES = `LSAL_LANES,
  parameter int DW = `LSAL_DATA_W,
  parameter int LAT_W = `LSAL_LAT_W
) (
  // Clock, reset and enable
  input logic core_clk,
  input logic sys_rst,
  input logic clk_en,

  // Resets from the reset sequencer
  input logic frame_rst_n,
  input logic [`LSAL_INST-1:0] link_rst_n,

  // Receiver link status per instance
  input logic [`LSAL_INST-1:0] rx_sync_n,
  input logic [`LSAL_INST*LANES-1:0] lane_aligned,
  input logic [`LSAL_INST-1:0] rx_dev_sync_n,

  // Link layer interrupts per instance
  input logic [`LSAL_INST-1:0] receive_link_interrupt,
  input logic [`LSAL_INST-1:0] transmit_link_interrupt,

  // Pattern checker status, frame clock domain
  input lsal_pkg::lsal_chk_t chk_err_n,

  // Latency markers per instance
  input logic [`LSAL_INST-1:0] transmitter_link_ready,
  input logic [`LSAL_INST-1:0] receiver_link_valid,

  // Status register 0 values read back from each core
  input logic [`LSAL_INST*`LSAL_STAT_W-1:0] tx_status0,
  input logic [`LSAL_INST*`LSAL_STAT_W-1:0] rx_status0,

  // Receive transport pattern sources
  input logic [1:0] pattern_source_setting,
  input logic [DW-1:0] prbs_data,
  input logic [DW-1:0] ramp_data,
  input logic [DW-1:0] alt_data,

  // Indicators and combined link signals
  output lsal_pkg::lsal_ind_t led,
  output logic tx_dev_sync_n,
  output logic alldev_lane_aligned,

  // Receive transport output
  output logic [DW-1:0] rx_dataout,

  // Bring-up summary
  output logic status_ok,
  output logic bringup_ok,

  // Latency results
  output lsal_pkg::lsal_lat_t [`LSAL_INST-1:0] link_latency
);

  // ---------------------------------------------------------------
  // Local types and helpers
  // ---------------------------------------------------------------

  typedef struct packed {
    lsal_pkg::lsal_ind_t ind;
    logic tx_sync_n;
    logic aligned;
    logic stat_ok;
    logic up_ok;
    logic [DW-1:0] dout;
  } lsal_top_st_t;

  // Checks one instance pair of status 0 words
  function automatic logic lsal_stat_match(
    input logic [`LSAL_STAT_W-1:0] tx_word,
    input logic [`LSAL_STAT_W-1:0] rx_word
  );
    lsal_stat_match = (tx_word == `LSAL_TX_STAT0_OK) &&
                      (rx_word == `LSAL_RX_STAT0_OK);
  endfunction

  // Picks one pattern word from the source setting
  function automatic logic [DW-1:0] lsal_pick(
    input logic [1:0] sel,
    input logic [DW-1:0] prbs,
    input logic [DW-1:0] ramp,
    input logic [DW-1:0] alt
  );
    case (sel)
      `LSAL_SRC_PRBS: lsal_pick = prbs;
      `LSAL_SRC_RAMP: lsal_pick = ramp;
      `LSAL_SRC_ALT: lsal_pick = alt;
      default: lsal_pick = '0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Crossing from the frame domain and reset sequencer
  // ---------------------------------------------------------------

  logic [`LSAL_FRM_SYNC_W-1:0] frm_sync;
  logic [`LSAL_INST-1:0] lnk_rst_sync;
  logic frame_up_s;
  logic chk_ok_s;

  // frame clock is related but skewed, so still resync
  lsal_sync2 #(
    .W(`LSAL_FRM_SYNC_W),
    .RST_VAL(`LSAL_FRM_SYNC_RST)
  ) u_frm_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in({chk_err_n, frame_rst_n}),
    .sync_out(frm_sync)
  );

  // Sequencer resets release asynchronously
  lsal_sync2 #(
    .W(`LSAL_INST),
    .RST_VAL(`LSAL_LNK_SYNC_RST)
  ) u_lnk_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(link_rst_n),
    .sync_out(lnk_rst_sync)
  );

  assign frame_up_s = frm_sync[0];
  assign chk_ok_s = &frm_sync[`LSAL_FRM_SYNC_W-1:1];

  // ---------------------------------------------------------------
  // Status combining
  // ---------------------------------------------------------------

  lsal_top_st_t s_q;
  lsal_top_st_t s_d;
  logic [`LSAL_INST-1:0] stat_match;

  // Status words compared per instance
  always_comb begin
    for (int i = 0; i < `LSAL_INST; i++) begin
      stat_match[i] = lsal_stat_match(
        tx_status0[i*`LSAL_STAT_W +: `LSAL_STAT_W],
        rx_status0[i*`LSAL_STAT_W +: `LSAL_STAT_W]);
    end
  end

  // Next state of all lamps and combined signals
  always_comb begin
    s_d = s_q;
    s_d.ind.frame_up = frame_up_s;
    // both cores out of link reset
    s_d.ind.link_up = &lnk_rst_sync;
    // sync released once K28.5 seen on all receivers
    s_d.ind.rx_sync = &rx_sync_n;
    s_d.aligned = &lane_aligned;
    s_d.ind.lanes_aligned = &lane_aligned;
    s_d.tx_sync_n = &rx_dev_sync_n;
    s_d.ind.tx_sync = &rx_dev_sync_n;
    s_d.ind.rx_irq = |receive_link_interrupt;
    s_d.ind.tx_irq = |transmit_link_interrupt;
    // lamp lights on any data error
    s_d.ind.data_err = ~chk_ok_s;
    s_d.dout = lsal_pick(pattern_source_setting, prbs_data,
                         ramp_data, alt_data);
    s_d.stat_ok = &stat_match;
    // lamps that must be on, and those that must be off
    s_d.up_ok = s_q.ind.frame_up & s_q.ind.link_up &
                s_q.ind.rx_sync & s_q.ind.lanes_aligned &
                s_q.ind.tx_sync & ~s_q.ind.rx_irq &
                ~s_q.ind.tx_irq & ~s_q.ind.data_err;
    // Enable low freezes everything
    if (!clk_en) begin
      s_d = s_q;
    end
  end

  // single registered stage on the link clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      // Sync stays requested until the receivers say otherwise
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Latency measurement per instance
  // ---------------------------------------------------------------

  // Separate counters so a late instance shows its own skew
  for (genvar g = 0; g < `LSAL_INST; g++) begin : g_lat
    lsal_lat_cnt #(
      .LAT_W(LAT_W)
    ) u_lat (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .link_rst_n(lnk_rst_sync[g]),
      .tx_ready(transmitter_link_ready[g]),
      .rx_valid(receiver_link_valid[g]),
      .done(link_latency[g].done),
      .count(link_latency[g].count)
    );
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  // All outputs but link_latency come straight from the state register
  assign led = s_q.ind;
  assign tx_dev_sync_n = s_q.tx_sync_n;
  assign alldev_lane_aligned = s_q.aligned;
  assign rx_dataout = s_q.dout;
  assign status_ok = s_q.stat_ok;
  assign bringup_ok = s_q.up_ok;

endmodule

// ==== tb/lsal_link_model.sv ====
`include "lsal_map.svh"

// ----
// Pair of link cores as the block sees them
// ----
module lsal_link_model (
  // Clock
  input logic core_clk,
  // Bring-up per core, ready to valid spacing, spoilt status
  input logic [`LSAL_INST-1:0] up,
  input logic [7:0] dly,
  input logic bad,
  // Link status towards the block
  output logic [`LSAL_INST-1:0] tx_ready,
  output logic [`LSAL_INST-1:0] rx_valid,
  output logic [`LSAL_INST*`LSAL_LANES-1:0] lanes,
  output logic [`LSAL_INST*`LSAL_STAT_W-1:0] tx_stat,
  output logic [`LSAL_INST*`LSAL_STAT_W-1:0] rx_stat
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [`LSAL_INST];

  // Ready one edge after the request, valid dly edges after ready
  always @(posedge core_clk) begin
    for (int i = 0; i < `LSAL_INST; i++) begin
      tx_ready[i] <= up[i];
      cnt[i] <= up[i] ? cnt[i] + 1 : 0;
      rx_valid[i] <= up[i] && cnt[i] >= int'(dly);
    end
  end

  always_comb begin
    for (int i = 0; i < `LSAL_INST; i++) begin
      lanes[i*8+:8] = {8{rx_valid[i]}};
      tx_stat[i*32+:32] = rx_valid[i] ? `LSAL_TX_STAT0_OK : 32'h0000_0000;
      // Only a spoilt word may differ, so a loose compare gets caught
      rx_stat[i*32+:32] = rx_valid[i] ?
        `LSAL_RX_STAT0_OK ^ {31'h0000_0000, bad} : 32'h0000_0000;
    end
  end
endmodule

// ==== tb/lsal_top_sva.sv ====
`include "lsal_map.svh"

// ----
// Checker on the block ports
// ----
module lsal_top_sva #(
  parameter int LANES = `LSAL_LANES,
  parameter int LAT_W = `LSAL_LAT_W
) (
  // Clock, reset, enable
  input logic core_clk,
  input logic sys_rst,
  input logic clk_en,
  // Inputs watched
  input logic frame_rst_n,
  input logic [`LSAL_INST-1:0] link_rst_n,
  input logic [`LSAL_INST-1:0] rx_sync_n,
  input logic [`LSAL_INST*LANES-1:0] lane_aligned,
  input logic [`LSAL_INST-1:0] rx_dev_sync_n,
  input logic [`LSAL_INST-1:0] receive_link_interrupt,
  input logic [`LSAL_INST-1:0] transmit_link_interrupt,
  input lsal_pkg::lsal_chk_t chk_err_n,
  input logic [`LSAL_INST-1:0] receiver_link_valid,
  // Outputs watched
  input lsal_pkg::lsal_ind_t led,
  input logic tx_dev_sync_n,
  input logic alldev_lane_aligned,
  input lsal_pkg::lsal_lat_t [`LSAL_INST-1:0] link_latency
);
  // Enable sits in antecedents, since a frozen edge keeps old lamps
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  AST_FRAME_UP: assert property (
    (frame_rst_n && clk_en)[*3] |=> led.frame_up) else $error("frame");
  AST_LINK_UP: assert property (
    (&link_rst_n && clk_en)[*3] |=> led.link_up) else $error("link");
  AST_RX_SYNC: assert property (
    clk_en |=> led.rx_sync == &$past(rx_sync_n)) else $error("sync");
  AST_ALIGN: assert property (
    clk_en |=> alldev_lane_aligned == &$past(lane_aligned) &&
    led.lanes_aligned == alldev_lane_aligned) else $error("align");
  AST_TX_SYNC: assert property (
    clk_en |=> tx_dev_sync_n == &$past(rx_dev_sync_n)) else $error("txs");
  AST_RX_IRQ: assert property (
    clk_en |=> led.rx_irq == |$past(receive_link_interrupt))
    else $error("irq");
  AST_TX_IRQ: assert property (
    clk_en |=> led.tx_irq == |$past(transmit_link_interrupt))
    else $error("tx irq");
  AST_DATA_ERR: assert property (
    (!(&{chk_err_n}) && clk_en)[*3] |=> led.data_err) else $error("err");
  AST_LAT_CLR: assert property (
    clk_en && !$past(link_rst_n[0], 2) |=> link_latency[0].count == '0 &&
    !link_latency[0].done) else $error("clear");
  AST_LAT_RUN: assert property (
    clk_en && !link_latency[0].done && link_latency[0].count != '0 &&
    link_latency[0].count != '1 && !receiver_link_valid[0] &&
    $past(link_rst_n[0], 2) |=> link_latency[0].count ==
    $past(link_latency[0].count) + 1'h1) else $error("run");

  // Main scenarios reached
  cover property (led == 8'h1f);
  cover property (link_latency[0].done);
  cover property (led.data_err);
endmodule

bind lsal_top lsal_top_sva #(.LANES(LANES), .LAT_W(LAT_W)) u_sva (
  .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .frame_rst_n(frame_rst_n), .link_rst_n(link_rst_n),
  .rx_sync_n(rx_sync_n), .lane_aligned(lane_aligned),
  .rx_dev_sync_n(rx_dev_sync_n), .chk_err_n(chk_err_n),
  .receive_link_interrupt(receive_link_interrupt),
  .transmit_link_interrupt(transmit_link_interrupt),
  .receiver_link_valid(receiver_link_valid), .led(led),
  .tx_dev_sync_n(tx_dev_sync_n), .alldev_lane_aligned(alldev_lane_aligned),
  .link_latency(link_latency));

// ==== tb/lsal_top_tb.sv ====
`include "lsal_map.svh"

// ----
// Bench for the status and latency block
// ----
module lsal_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [255:0] PRBS = {8{32'h1357_9bdf}};
  localparam logic [255:0] RAMP = {8{32'h0001_0203}};
  localparam logic [255:0] ALT = {8{32'haaaa_5555}};
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic clk_en = 1'h1;
  logic frame_rst_n = 1'h0;
  logic [1:0] link_rst_n = 2'h0;
  logic [1:0] rx_irq = 2'h0;
  logic [1:0] tx_irq = 2'h0;
  lsal_pkg::lsal_chk_t chk_err_n = 6'h3f;
  logic [1:0] sel = 2'h0;
  logic [1:0] up = 2'h0;
  logic [7:0] dly = 8'h00;
  logic bad = 1'h0;
  logic [1:0] rdy, vld;
  logic [15:0] lanes;
  logic [63:0] tx_st, rx_st;
  logic [255:0] dout;
  lsal_pkg::lsal_ind_t led;
  lsal_pkg::lsal_lat_t [1:0] lat;
  logic txs_n, alld, st_ok, bu_ok;
  int miscompares = 0;
  int samples_checked = 0;

  // Link clock, 4 ns
  always #2 core_clk = ~core_clk;

  // Block and the link cores beside it
  lsal_top u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .frame_rst_n(frame_rst_n), .link_rst_n(link_rst_n), .rx_sync_n(vld),
    .lane_aligned(lanes), .rx_dev_sync_n(vld), .chk_err_n(chk_err_n),
    .receive_link_interrupt(rx_irq), .transmit_link_interrupt(tx_irq),
    .transmitter_link_ready(rdy), .receiver_link_valid(vld),
    .tx_status0(tx_st), .rx_status0(rx_st), .pattern_source_setting(sel),
    .prbs_data(PRBS), .ramp_data(RAMP), .alt_data(ALT), .led(led),
    .tx_dev_sync_n(txs_n), .alldev_lane_aligned(alld), .rx_dataout(dout),
    .status_ok(st_ok), .bringup_ok(bu_ok), .link_latency(lat));
  lsal_link_model u_link (.core_clk(core_clk), .up(up), .dly(dly),
    .bad(bad), .tx_ready(rdy), .rx_valid(vld), .lanes(lanes),
    .tx_stat(tx_st), .rx_stat(rx_st));

  // Compare one value, four-state exact
  task automatic chk(input logic [255:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  // Sample just after an edge so its updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Lamps leave reset dark, then follow the synchronised resets
  task automatic t_resets;
    step(1);
    chk({led, lat}, 40'h0, "reset state");
    @(posedge core_clk);
    frame_rst_n <= 1'h1;
    link_rst_n <= 2'h1;
    step(2);
    chk(led.frame_up, 1'h0, "frame early");
    step(2);
    chk(led[1:0], 2'h1, "frame only");
    @(posedge core_clk);
    link_rst_n <= 2'h3;
    step(4);
    chk(led[1:0], 2'h3, "link lamp");
    $display("resets test done");
  endtask

  // Latency at zero, one and thirty clocks; clear on link reset, then hold
  task automatic t_latency;
    int d [3] = '{0, 1, 30};
    logic [15:0] e;
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      up <= 2'h0;
      link_rst_n <= 2'h0;
      dly <= 8'(d[i]);
      step(4);
      chk(lat, 32'h0, "not cleared");
      @(posedge core_clk);
      link_rst_n <= 2'h3;
      step(4);
      @(posedge core_clk);
      up <= 2'h3;
      step(d[i] + 6);
      e = {1'h1, 15'(d[i] == 0 ? 0 : d[i] - 1)};
      chk(lat, {e, e}, "latency");
      step(9);
      chk(lat, {e, e}, "not held");
    end
    $display("latency test done");
  endtask

  // Full bring-up, one core lost, then a spoilt status word
  task automatic t_bringup;
    chk({led, alld, txs_n, st_ok, bu_ok}, 12'h1ff, "up");
    @(posedge core_clk);
    up <= 2'h1;
    step(4);
    chk({led, alld, txs_n, st_ok, bu_ok}, 12'h030, "one");
    @(posedge core_clk);
    up <= 2'h3;
    bad <= 1'h1;
    step(40);
    chk({led, st_ok, bu_ok}, 10'h07d, "bad status");
    @(posedge core_clk);
    bad <= 1'h0;
    $display("bring-up test done");
  endtask

  // Interrupt lamps over all pairs, then each checker error bit alone
  task automatic t_events;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      rx_irq <= 2'(i);
      tx_irq <= 2'(3 - i);
      step(2);
      chk(led.rx_irq, i != 0, "rx irq");
      chk(led.tx_irq, i != 3, "tx irq");
    end
    for (int i = 0; i < 7; i++) begin
      @(posedge core_clk);
      tx_irq <= 2'h0;
      chk_err_n <= i < 6 ? ~(6'h01 << i) : 6'h3f;
      step(4);
      chk(led.data_err, i < 6, "data error");
    end
    $display("events test done");
  endtask

  // Every pattern source setting
  task automatic t_pattern;
    logic [255:0] e [4] = '{PRBS, RAMP, ALT, 256'h0};
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      sel <= 2'(i);
      step(2);
      chk(dout, e[i], "pattern");
    end
    // Enable low must freeze the output word
    @(posedge core_clk);
    clk_en <= 1'h0;
    sel <= 2'h0;
    step(3);
    chk(dout, 256'h0, "frozen");
    @(posedge core_clk);
    clk_en <= 1'h1;
    step(2);
    chk(dout, PRBS, "thawed");
    $display("pattern test done");
  endtask

  // Counts and verdict
  task automatic test_done;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'h0;
    t_resets;
    t_latency;
    t_bringup;
    t_events;
    t_pattern;
    test_done;
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #8000;
    miscompares++;
    test_done;
  end
endmodule
